// >>> rtl/eia_irq_ctrl.sv
// External edge detection and maskable interrupt acceptance, with APB registers.
//
// Contract
// - Eight pins, rise and fall enable registers.
// - Enable pair selects none, fall, rise, both.
// - Reset clears both edge enable registers.
// - Edge enables take bit and byte writes.
// - Status word holds enable, priority; resets 02.
// - Status word: byte, bit, enable/disable instructions.
// - Eligible when request set and unmasked.
// - Accept only while enable bit is set.
// - High handler active blocks low requests.
// - Minimum latency seven or eight clocks.
// - Maximum latency thirty-two or thirty-three clocks.
// - Higher programmed priority level wins.
// - Equal level: fixed default priority wins.
// - Pending request accepted once conditions hold.
// - Push status, push pc, clear enable, vector.
// - Returns and status pop restore word.
// - Break pushes status, clears enable bit.
// - In-service bit zero means high handler.
// - Priority flag zero is the higher level.
`timescale 1ns/1ps
`default_nettype none
module eia_irq_ctrl
   import eia_pkg::*;
#(
   parameter int          NSRC     = 8,
   parameter logic [15:0] VEC_BASE = 16'h0006
) (
   // Clock, reset and clock enable.
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // APB slave.
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [17:0]      paddr,
   input  wire logic [31:0]      pwdata,
   input  wire logic [3:0]       pstrb,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // External interrupt pins.
   input  wire logic [NSRC-1:0]  external_irq_input,
   // CPU core: instruction events.
   input  wire logic             cpu_instr_boundary,
   input  wire logic [15:0]      cpu_pc,
   input  wire logic             enable_irq_instr,
   input  wire logic             disable_irq_instr,
   input  wire logic             break_instruction,
   input  wire logic             interrupt_return,
   input  wire logic             break_return,
   input  wire logic             pop_status_instr,
   input  wire logic [7:0]       stack_pop_data,
   // CPU core: acceptance sequence outputs.
   output logic                  stack_push_status_instr,
   output logic      [7:0]       stack_psw_data,
   output logic                  stack_push_pc,
   output logic      [15:0]      stack_pc_data,
   output logic                  vector_load,
   output logic      [15:0]      vector_addr,
   output logic                  handler_entry,
   output logic                  accept_busy,
   output logic      [7:0]       program_status_word
);

   // Register storage.
   logic [NSRC-1:0] rise_edge_enable_ff;  // Rising-edge enables.
   logic [NSRC-1:0] fall_edge_enable_ff;  // Falling-edge enables.
   logic [NSRC-1:0] req_flag_ff;          // Pending request flags.
   logic [NSRC-1:0] mask_flag_ff;         // 1 masks the source.
   logic [NSRC-1:0] priority_flag_ff;     // 0 is the higher level.
   logic [7:0]      psw_ff;               // Program status word.

   // Acceptance sequencer.
   eia_state_t      state_ff;             // Current step.
   eia_state_t      nxt_state;            // Next step.
   logic [3:0]      wait_ff;              // Remaining wait cycles.
   logic [2:0]      src_ff;               // Accepted source.
   logic [7:0]      saved_psw_ff;         // Status word before acceptance.
   logic [15:0]     saved_pc_ff;          // Return address.
   logic [15:0]     vec_addr_ff;          // Vector entry address.

   // Combinational helpers.
   logic [NSRC-1:0] edge_hit;             // Valid edges this cycle.
   logic [NSRC-1:0] eligible;             // Requested and unmasked.
   logic [NSRC-1:0] cand;                 // Candidates after priority gating.
   logic            win_any;              // Some source may be accepted.
   logic [2:0]      win_idx;              // Winning source index.
   logic            do_accept;            // Acceptance happens this cycle.
   logic            wr_en;                // APB write strobe.
   logic            rd_en;                // APB read strobe.
   logic [15:0]     reg_idx;              // Word index of the access.
   logic            addr_hit;             // Access maps to a register.

   // Edge detection on all eight pins.
   eia_edge_detect #(
      .WIDTH (NSRC)
   ) u_edge (
      .pclk               (pclk),
      .presetn            (presetn),
      .ce                 (ce),
      .external_irq_input (external_irq_input),
      .rise_edge_enable   (rise_edge_enable_ff),
      .fall_edge_enable   (fall_edge_enable_ff),
      .edge_hit           (edge_hit)
   );

   // APB decode: zero wait states, so pready is always high.
   assign reg_idx = paddr[17:2];
   assign wr_en   = psel && penable && pwrite && ce;
   assign rd_en   = psel && penable && !pwrite;
   assign pready  = 1'b1;

   // Unmapped or misaligned addresses answer with an error and store nothing.
   always_comb begin
      case (reg_idx)
         IDX_RISE_EN, IDX_FALL_EN, IDX_REQ, IDX_MASK, IDX_PRIO, IDX_PSW, IDX_STATUS: begin
            addr_hit = (paddr[1:0] == 2'b00);
         end
         default: begin
            addr_hit = 1'b0;
         end
      endcase
   end
   assign pslverr = psel && penable && !addr_hit;

   // Applies a byte write or a single-bit write to an 8-bit register.
   // Only the lane 0 strobe matters, though pwdata[8] selects bit mode; with pstrb[0] low nothing changes.
   function automatic logic [7:0] apply_wr(input logic [7:0]  cur,
                                           input logic [31:0] wd,
                                           input logic [3:0]  strb);
      logic [7:0] res;
      res = cur;
      if (strb[0]) begin
         if (wd[WR_BITMODE_BIT]) begin
            res[wd[2:0]] = wd[WR_BITVAL_BIT];
         end else begin
            res = wd[7:0];
         end
      end
      return res;
   endfunction : apply_wr

   // Selected write strobes per register.
   logic wr_rise;
   logic wr_fall;
   logic wr_req;
   logic wr_mask;
   logic wr_prio;
   logic wr_psw;
   assign wr_rise = wr_en && addr_hit && (reg_idx == IDX_RISE_EN);
   assign wr_fall = wr_en && addr_hit && (reg_idx == IDX_FALL_EN);
   assign wr_req  = wr_en && addr_hit && (reg_idx == IDX_REQ);
   assign wr_mask = wr_en && addr_hit && (reg_idx == IDX_MASK);
   assign wr_prio = wr_en && addr_hit && (reg_idx == IDX_PRIO);
   assign wr_psw  = wr_en && addr_hit && (reg_idx == IDX_PSW);

   // Edge enable registers. Clearing both bits before the pin is handed
   // to port use is software's job; the detector cannot tell the two apart.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rise_edge_enable_ff <= RST_EDGE_EN;
         fall_edge_enable_ff <= RST_EDGE_EN;
      end else begin
         if (wr_rise) begin
            rise_edge_enable_ff <= apply_wr(rise_edge_enable_ff, pwdata, pstrb);
         end
         if (wr_fall) begin
            fall_edge_enable_ff <= apply_wr(fall_edge_enable_ff, pwdata, pstrb);
         end
      end
   end

   // Mask and priority flags, software owned.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_flag_ff     <= RST_MASK;
         priority_flag_ff <= RST_PRIO;
      end else begin
         if (wr_mask) begin
            mask_flag_ff <= apply_wr(mask_flag_ff, pwdata, pstrb);
         end
         if (wr_prio) begin
            priority_flag_ff <= apply_wr(priority_flag_ff, pwdata, pstrb);
         end
      end
   end

   // Request flags. Order matters: software write, then acceptance clear,
   // then a fresh edge, so an edge in the clearing cycle is never lost.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_flag_ff <= RST_REQ;
      end else if (ce) begin
         logic [NSRC-1:0] nxt_req;
         nxt_req = req_flag_ff;
         if (wr_req) begin
            nxt_req = apply_wr(req_flag_ff, pwdata, pstrb);
         end
         if (do_accept) begin
            nxt_req[win_idx] = 1'b0;
         end
         nxt_req = nxt_req | edge_hit;
         req_flag_ff <= nxt_req;
      end
   end

   assign eligible = req_flag_ff & ~mask_flag_ff;

   // Candidate selection: the higher level group if it has any member,
   // otherwise the lower level, unless a high handler is in service.
   always_comb begin
      cand = '0;
      if (|(eligible & ~priority_flag_ff)) begin
         cand = eligible & ~priority_flag_ff;
      end else if (psw_ff[PSW_ISP_BIT]) begin
         cand = eligible;
      end
   end

   always_comb begin
      win_any = 1'b0;
      win_idx = 3'h0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (cand[i]) begin
            win_any = 1'b1;
            win_idx = 3'(i);
         end
      end
   end

   // Pending taken when allowed.
   // A break in the same boundary takes precedence; it clears the enable bit.
   assign do_accept = ce && (state_ff == EIA_IDLE) && cpu_instr_boundary && win_any
                    && psw_ff[PSW_IE_BIT] && !break_instruction;

   // Program status word. Hardware events are applied after the software
   // write so an acceptance or break always leaves the enable bit cleared.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psw_ff <= RST_PSW;
      end else if (ce) begin
         logic [7:0] nxt_psw;
         nxt_psw = psw_ff;
         if (wr_psw) begin
            nxt_psw = apply_wr(psw_ff, pwdata, pstrb);
         end
         if (enable_irq_instr) begin
            nxt_psw[PSW_IE_BIT] = 1'b1;
         end
         if (disable_irq_instr) begin
            nxt_psw[PSW_IE_BIT] = 1'b0;
         end
         if (interrupt_return || break_return || pop_status_instr) begin
            nxt_psw = stack_pop_data;
         end
         if (break_instruction) begin
            nxt_psw[PSW_IE_BIT] = 1'b0;
         end
         if (do_accept) begin
            nxt_psw[PSW_IE_BIT]  = 1'b0;
            nxt_psw[PSW_ISP_BIT] = priority_flag_ff[win_idx];
         end
         psw_ff <= nxt_psw;
      end
   end

   // Sequencer state register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= EIA_IDLE;
      end else if (ce) begin
         state_ff <= nxt_state;
      end
   end

   // Sequencer transitions: wait out the latency, then push, vector, enter.
   always_comb begin
      case (state_ff)
         EIA_IDLE: begin
            nxt_state = do_accept ? EIA_WAIT : EIA_IDLE;
         end
         EIA_WAIT: begin
            nxt_state = (wait_ff == 4'h1) ? EIA_PUSH_STATUS_INSTR : EIA_WAIT;
         end
         EIA_PUSH_STATUS_INSTR: begin
            nxt_state = EIA_PUSH_PC;
         end
         EIA_PUSH_PC: begin
            nxt_state = EIA_VECTOR;
         end
         EIA_VECTOR: begin
            nxt_state = EIA_ENTRY;
         end
         EIA_ENTRY: begin
            nxt_state = EIA_IDLE;
         end
         default: begin
            nxt_state = EIA_IDLE;
         end
      endcase
   end

   // Wait counter. The entry lands exactly at the minimum latency after the
   // request flag first shows; the maximum depends on how soon the core
   // reaches an instruction boundary, which this block cannot shorten.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_ff <= 4'h0;
      end else if (ce) begin
         if (do_accept) begin
            wait_ff <= priority_flag_ff[win_idx] ? WAIT_LO : WAIT_HI;
         end else if (state_ff == EIA_WAIT) begin
            wait_ff <= wait_ff - 4'h1;
         end
      end
   end

   // Capture everything the push and vector steps need at acceptance.
   // A break captures the status word too so its push carries the old value.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_ff       <= 3'h0;
         saved_psw_ff <= RST_PSW;
         saved_pc_ff  <= 16'h0000;
         vec_addr_ff  <= 16'h0000;
      end else if (ce) begin
         if (do_accept) begin
            src_ff       <= win_idx;
            saved_psw_ff <= psw_ff;
            saved_pc_ff  <= cpu_pc;
            vec_addr_ff  <= VEC_BASE + {12'h000, win_idx, 1'b0};
         end else if (break_instruction && state_ff == EIA_IDLE) begin
            saved_psw_ff <= psw_ff;
         end
      end
   end

   // Break push pulse, one clock after the break instruction.
   logic brk_push_ff; // Pending break status push.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         brk_push_ff <= 1'b0;
      end else if (ce) begin
         brk_push_ff <= break_instruction && (state_ff == EIA_IDLE);
      end
   end

   // Status first, then pc, then vector.
   assign stack_push_status_instr      = (state_ff == EIA_PUSH_STATUS_INSTR) || brk_push_ff;
   assign stack_psw_data      = saved_psw_ff;
   assign stack_push_pc       = (state_ff == EIA_PUSH_PC);
   assign stack_pc_data       = saved_pc_ff;
   assign vector_load         = (state_ff == EIA_VECTOR);
   assign vector_addr         = vec_addr_ff;
   assign handler_entry       = (state_ff == EIA_ENTRY);
   assign accept_busy         = (state_ff != EIA_IDLE);
   assign program_status_word = psw_ff;

   // Read mux. Reads have no side effects, so no clock enable is needed.
   always_comb begin
      prdata = 32'h0000_0000;
      if (rd_en && addr_hit) begin
         case (reg_idx)
            IDX_RISE_EN: prdata[7:0] = rise_edge_enable_ff;
            IDX_FALL_EN: prdata[7:0] = fall_edge_enable_ff;
            IDX_REQ:     prdata[7:0] = req_flag_ff;
            IDX_MASK:    prdata[7:0] = mask_flag_ff;
            IDX_PRIO:    prdata[7:0] = priority_flag_ff;
            IDX_PSW:     prdata[7:0] = psw_ff;
            IDX_STATUS:  prdata[7:0] = {1'b0, state_ff, 1'b0, src_ff};
            default:     prdata      = 32'h0000_0000;
         endcase
      end
   end

endmodule : eia_irq_ctrl
`default_nettype wire

// >>> rtl/eia_pkg.sv
// Shared constants for the external edge and maskable interrupt acceptance block.
package eia_pkg;

   // Register indices; the APB byte address is four times the index.
   localparam logic [15:0] IDX_RISE_EN = 16'hff48;  // Rising-edge enables.
   localparam logic [15:0] IDX_FALL_EN = 16'hff49;  // Falling-edge enables.
   localparam logic [15:0] IDX_REQ     = 16'hff50;  // Request flags.
   localparam logic [15:0] IDX_MASK    = 16'hff51;  // Mask flags.
   localparam logic [15:0] IDX_PRIO    = 16'hff52;  // Priority flags.
   localparam logic [15:0] IDX_PSW     = 16'hff53;  // Program status word.
   localparam logic [15:0] IDX_STATUS  = 16'hff54;  // Read-only sequencer status.

   // Reset values.
   localparam logic [7:0] RST_EDGE_EN = 8'h00;
   localparam logic [7:0] RST_REQ     = 8'h00;
   localparam logic [7:0] RST_MASK    = 8'hff;
   localparam logic [7:0] RST_PRIO    = 8'hff;
   localparam logic [7:0] RST_PSW     = 8'h02;

   // Field positions in the program status word.
   localparam int PSW_IE_BIT  = 7;  // Maskable accept enable.
   localparam int PSW_ISP_BIT = 1;  // In-service priority.

   // Bit-manipulation write format: pwdata[8] selects it, [2:0] bit, [3] value.
   localparam int WR_BITMODE_BIT = 8;
   localparam int WR_BITVAL_BIT  = 3;

   // Request-to-entry latency in CPU clocks, high and low priority.
   localparam int LAT_HI_CLK = 7;
   localparam int LAT_LO_CLK = 8;
   // Fixed cycles spent after acceptance: push status, push pc, vector, entry,
   // plus the cycle in which the request flag first shows.
   localparam int SEQ_FIXED_CLK = 5;
   localparam logic [3:0] WAIT_HI = 4'(LAT_HI_CLK - SEQ_FIXED_CLK);
   localparam logic [3:0] WAIT_LO = 4'(LAT_LO_CLK - SEQ_FIXED_CLK);

   // Acceptance sequencer states, Gray coded along the path.
   typedef enum logic [2:0] {
      EIA_IDLE     = 3'b000,
      EIA_WAIT     = 3'b001,
      EIA_PUSH_STATUS_INSTR = 3'b011,
      EIA_PUSH_PC  = 3'b010,
      EIA_VECTOR   = 3'b110,
      EIA_ENTRY    = 3'b111
   } eia_state_t;

endpackage : eia_pkg

// >>> rtl/eia_edge_detect.sv
// Per-pin valid-edge detector for the external interrupt inputs.
`timescale 1ns/1ps
`default_nettype none
module eia_edge_detect
   import eia_pkg::*;
#(
   parameter int WIDTH = 8
) (
   // Clock and reset.
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // Pins and enables.
   input  wire logic [WIDTH-1:0] external_irq_input,
   input  wire logic [WIDTH-1:0] rise_edge_enable,
   input  wire logic [WIDTH-1:0] fall_edge_enable,
   // One-cycle edge pulses.
   output logic      [WIDTH-1:0] edge_hit
);

   logic [WIDTH-1:0] prev_ff;   // Pin level seen one clock earlier.
   logic             primed_ff; // Low until the first sample is held.

   // Remember the last level; the first sample after reset is not compared,
   // so a pin that idles high does not look like a rising edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff   <= '0;
         primed_ff <= 1'b0;
      end else if (ce) begin
         prev_ff   <= external_irq_input;
         primed_ff <= 1'b1;
      end
   end

   always_comb begin
      edge_hit = '0;
      if (primed_ff && ce) begin
         edge_hit = (rise_edge_enable & external_irq_input & ~prev_ff)
                  | (fall_edge_enable & ~external_irq_input & prev_ff);
      end
   end

endmodule : eia_edge_detect
`default_nettype wire

// >>> dv/eia_irq_ctrl_assertions.sv
// Port-level checker for the edge detect and maskable acceptance block.
`timescale 1ns/1ps
`default_nettype none
module eia_chk
   import eia_pkg::*;
(
   // Clock and reset.
   input wire logic       pclk,
   input wire logic       presetn,
   // Core events.
   input wire logic       enable_irq_instr,
   input wire logic       disable_irq_instr,
   input wire logic       break_instruction,
   // Acceptance sequence.
   input wire logic       stack_push_status_instr,
   input wire logic [7:0] stack_psw_data,
   input wire logic       stack_push_pc,
   input wire logic       vector_load,
   input wire logic       handler_entry,
   input wire logic       accept_busy,
   input wire logic [7:0] program_status_word
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_psw_then_pc: assert property (stack_push_status_instr && accept_busy |=> stack_push_pc)
      else $error("status push not followed by pc push");
   a_pc_vec_entry: assert property (stack_push_pc |=> vector_load ##1 handler_entry)
      else $error("pc push not followed by vector then entry");
   a_accept_needs_ie: assert property ($rose(accept_busy) |-> $past(program_status_word[PSW_IE_BIT]))
      else $error("acceptance with enable bit clear");
   a_accept_clears_ie: assert property ($rose(accept_busy) |-> !program_status_word[PSW_IE_BIT])
      else $error("enable bit not cleared on acceptance");
   a_lat_high: assert property ($rose(accept_busy) && !program_status_word[PSW_ISP_BIT]
      |-> ##5 handler_entry)
      else $error("high level entry late");
   a_lat_low: assert property ($rose(accept_busy) && program_status_word[PSW_ISP_BIT]
      |-> ##6 handler_entry)
      else $error("low level entry late");
   a_break_push: assert property (break_instruction && !accept_busy |=> stack_push_status_instr
      && stack_psw_data == $past(program_status_word) && !program_status_word[PSW_IE_BIT])
      else $error("break did not push status and clear enable");
   a_di_clears: assert property (disable_irq_instr && !enable_irq_instr
      |=> !program_status_word[PSW_IE_BIT])
      else $error("disable pulse left enable bit set");
   a_psw_reset: assert property ($rose(presetn) |-> program_status_word == RST_PSW)
      else $error("status word wrong after reset");
endmodule : eia_chk
bind eia_irq_ctrl eia_chk u_chk (.pclk, .presetn, .enable_irq_instr, .disable_irq_instr,
   .break_instruction, .stack_push_status_instr, .stack_psw_data, .stack_push_pc, .vector_load,
   .handler_entry, .accept_busy, .program_status_word);
`default_nettype wire

// >>> dv/eia_cpu_model.sv
// Behavioural core: instruction boundaries, return address and a one-deep status stack.
`timescale 1ns/1ps
`default_nettype none
module eia_cpu_model #(
   parameter logic [15:0] PC_VAL = 16'h1234  // Arbitrary return address.
) (
   // Clock, reset and pace.
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        slow,
   // Stack traffic.
   input  wire logic        stack_push_status_instr,
   input  wire logic [7:0]  stack_psw_data,
   output logic             cpu_instr_boundary,
   output logic      [15:0] cpu_pc,
   output logic      [7:0]  stack_pop_data
);
   logic [1:0] cnt_ff;  // Slow mode offers a boundary one cycle in four.

   assign cpu_instr_boundary = !slow || cnt_ff == 2'h0;
   assign cpu_pc = PC_VAL;

   // The stack keeps what the block pushed, so a later return restores it.
   // saved status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 2'h0;
         stack_pop_data <= 8'h5a;
      end else begin
         cnt_ff <= cnt_ff + 2'h1;
         if (stack_push_status_instr) stack_pop_data <= stack_psw_data;
      end
   end
endmodule : eia_cpu_model
`default_nettype wire

// >>> dv/tb_ext_edge_and_maskable_irq_ack.sv
// Self-checking bench for the edge detect and maskable acceptance block.
`timescale 1ns/1ps
`default_nettype none
module tb_ext_edge_and_maskable_irq_ack;
   import eia_pkg::*;
   localparam logic [15:0] VB = 16'h0006;  // Vector table base.
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr, er, cpu_instr_boundary;
   logic [7:0]  external_irq_input = '0, stack_pop_data, stack_psw_data, program_status_word;
   logic [5:0]  op = '0;  // Pulses: enable, disable, break, return, break return, pop.
   logic [15:0] cpu_pc, stack_pc_data, vector_addr;
   logic        stack_push_status_instr, stack_push_pc, vector_load, handler_entry, accept_busy;
   int          mismatches = 0, checks_done = 0, n;

   eia_irq_ctrl #(.VEC_BASE(VB)) uut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .external_irq_input, .cpu_instr_boundary,
      .cpu_pc, .enable_irq_instr(op[5]), .disable_irq_instr(op[4]), .break_instruction(op[3]),
      .interrupt_return(op[2]), .break_return(op[1]), .pop_status_instr(op[0]), .stack_pop_data,
      .stack_push_status_instr, .stack_psw_data, .stack_push_pc, .stack_pc_data, .vector_load, .vector_addr,
      .handler_entry, .accept_busy, .program_status_word);
   eia_cpu_model cpu (.pclk, .presetn, .slow, .stack_push_status_instr, .stack_psw_data,
      .cpu_instr_boundary, .cpu_pc, .stack_pop_data);

   // Free-running 50 MHz clock.
   always #10 pclk = ~pclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; data and error are taken at the edge that sees pready,
   // then one idle edge so a following call never reassigns psel in one step.
   task automatic apb(input logic w, input logic [15:0] i, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {i, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic rdchk(input logic [15:0] i, input logic [31:0] e);
      apb(1'b0, i, 32'h0);
      chk(rd, e);
   endtask : rdchk
   // One-cycle instruction pulse, then an idle cycle so the next pulse is distinct.
   task automatic ins(input logic [5:0] m);
      op <= m;
      @(posedge pclk);
      op <= 6'h00;
      @(posedge pclk);
   endtask : ins
   // Bounded wait for handler entry; n counts edges from the call.
   task automatic wait_entry;
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (handler_entry !== 1'b1 && n < 60);
      rd = 32'(handler_entry);
      @(posedge pclk);
   endtask : wait_entry

   task automatic t_regs;
      rdchk(IDX_RISE_EN, 32'h0);
      rdchk(IDX_FALL_EN, 32'h0);
      rdchk(IDX_PSW, 32'h02);
      apb(1'b0, 16'h0000, 32'h0);
      chk(er, 1'b1);
      apb(1'b1, IDX_RISE_EN, 32'ha5);
      apb(1'b1, IDX_RISE_EN, 32'h102);
      rdchk(IDX_RISE_EN, 32'ha1);
      apb(1'b1, IDX_FALL_EN, 32'h10f);
      rdchk(IDX_FALL_EN, 32'h80);
      $display("regs done");
   endtask : t_regs
   // Every enable pair on pin 0, both edge directions; masks hold off acceptance.
   task automatic t_edges;
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, IDX_RISE_EN, {31'h0, m[1]});
         apb(1'b1, IDX_FALL_EN, {31'h0, m[0]});
         apb(1'b1, IDX_REQ, 32'h0);
         external_irq_input[0] <= 1'b1;
         rdchk(IDX_REQ, {31'h0, m[1]});
         apb(1'b1, IDX_REQ, 32'h0);
         external_irq_input[0] <= 1'b0;
         rdchk(IDX_REQ, {31'h0, m[0]});
      end
      apb(1'b1, IDX_RISE_EN, 32'h0);
      apb(1'b1, IDX_FALL_EN, 32'h0);
      $display("edges done");
   endtask : t_edges
   // Raise pins p together with enable set; source src must win.
   task automatic t_take(input logic [7:0] p, input logic [7:0] pr, input int src, input int lat);
      apb(1'b1, IDX_RISE_EN, {24'h0, p});
      apb(1'b1, IDX_PRIO, {24'h0, pr});
      apb(1'b1, IDX_MASK, {24'h0, ~p});
      ins(6'h20);
      external_irq_input <= p;
      wait_entry();
      chk(n, lat);
      chk(vector_addr, VB + 16'(2 * src));
      chk(program_status_word, {6'h00, pr[src], 1'b0});
      chk(stack_psw_data, 8'h82);
      chk(stack_pc_data, 16'h1234);
      apb(1'b1, IDX_MASK, 32'hff);
      apb(1'b1, IDX_REQ, 32'h0);
      external_irq_input <= 8'h00;
      ins(6'h04);
      chk(program_status_word, 8'h82);
      $display("take %0d done", src);
   endtask : t_take
   // Low request held by mask, in-service level and enable bit; slow core.
   task automatic t_pend;
      slow <= 1'b1;
      apb(1'b1, IDX_PRIO, 32'hff);
      apb(1'b1, IDX_RISE_EN, 32'h10);
      external_irq_input <= 8'h10;
      rdchk(IDX_REQ, 32'h10);
      chk(accept_busy, 1'b0);
      apb(1'b1, IDX_PSW, 32'h80);
      apb(1'b1, IDX_MASK, 32'hef);
      rdchk(IDX_REQ, 32'h10);
      chk(accept_busy, 1'b0);
      apb(1'b1, IDX_PSW, 32'h02);
      rdchk(IDX_REQ, 32'h10);
      chk(accept_busy, 1'b0);
      ins(6'h20);
      wait_entry();
      chk(rd, 1'b1);
      chk(program_status_word, 8'h02);
      apb(1'b1, IDX_MASK, 32'hff);
      external_irq_input <= 8'h00;
      apb(1'b1, IDX_RISE_EN, 32'h0);
      slow <= 1'b0;
      ins(6'h04);
      $display("pend done");
   endtask : t_pend
   task automatic t_break;
      op <= 6'h08;
      @(posedge pclk);
      op <= 6'h00;
      #1;
      chk(stack_push_status_instr, 1'b1);
      chk(program_status_word, 8'h02);
      @(posedge pclk);
      ins(6'h02);
      chk(program_status_word, 8'h82);
      ins(6'h10);
      chk(program_status_word, 8'h02);
      ins(6'h01);
      chk(program_status_word, 8'h82);
      apb(1'b1, IDX_PSW, 32'h107);
      rdchk(IDX_PSW, 32'h02);
      $display("break done");
   endtask : t_break

   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   // Main sequence.
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_edges();
      t_take(8'h08, 8'h00, 3, LAT_HI_CLK);
      t_take(8'h08, 8'hff, 3, LAT_LO_CLK);
      t_take(8'h22, 8'hdf, 5, LAT_HI_CLK);
      t_take(8'h44, 8'h00, 2, LAT_HI_CLK);
      t_pend();
      t_break();
      conclude();
   end
   // Watchdog: the run needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge pclk);
      mismatches++;
      conclude();
   end
endmodule : tb_ext_edge_and_maskable_irq_ack
`default_nettype wire
